//--- acs_defs.svh
// Purpose: Shared constants for the conversion sequencer and its host end.
// Assumes: One system clock mclk at 250 MHz; link clocks are sampled, not used as clocks.
// Notes:   Definitions only.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
`define ACS_CLK_NS        4
`define ACS_ACQ_CYCLES    4
`define ACS_ACQ_LATE      3
`define ACS_RES_BITS      14
`define ACS_SHIFT_BITS    15
`define ACS_CAL_CYCLES    14000
`define ACS_CONVERT_REQUEST_N_CYCLES   20
`define ACS_CLK_HALF_DIV  4
`define ACS_SCLK_HALF_DIV 4
`define ACS_FIFO_DEPTH    8
`define ACS_SYNC_W        3
`define ACS_RST_HOLD      8
`endif

//--- acs_pkg.sv
// Purpose: Types shared by both ends of the conversion sequencer link.
// Assumes: Included constants from acs_defs.svh.
// Notes:   States are one-hot.
`include "acs_defs.svh"
package acs_pkg;
  typedef enum logic [3:0] {
    ACS_CAL  = 4'h1,
    ACS_IDLE = 4'h2,
    ACS_CONVERT_REQUEST_N = 4'h4,
    ACS_WAIT = 4'h8
  } acs_dev_state_t;
  typedef enum logic [4:0] {
    ACS_H_RST   = 5'h01,
    ACS_H_CAL   = 5'h02,
    ACS_H_IDLE  = 5'h04,
    ACS_H_CONVERT_REQUEST_N  = 5'h08,
    ACS_H_READ  = 5'h10
  } acs_host_state_t;
endpackage

//--- acs_link_if.sv
// Purpose: Pins between the converter sequencer and its host.
// Assumes: All pins are driven one way; serial out is enabled by chip select.
// Notes:   Serial output level is resolved from its enable here.
`timescale 1ns/1ns
interface acs_link_if;
  logic convert_request_n;
  logic convert_request_n_clk;
  logic shift_clk;
  logic cs_n;
  logic reset_n;
  logic range_or_powerdown_select;
  logic sdout_o;
  logic sdout_oe;
  logic eoc;
  wire  sdout = sdout_oe ? sdout_o : 1'b0;
  modport device (
    input  convert_request_n, convert_request_n_clk, shift_clk, cs_n, reset_n, range_or_powerdown_select,
    output sdout_o, sdout_oe, eoc
  );
  modport host (
    output convert_request_n, convert_request_n_clk, shift_clk, cs_n, reset_n, range_or_powerdown_select,
    input  sdout, eoc
  );
endinterface

//--- acs_fifo.sv
// Purpose: Small synchronous FIFO for result words.
// Assumes: Depth is a power of two.
// Notes:   Ready on the write side falls when full.
`timescale 1ns/1ns
module acs_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // Write side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Read side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  wire              do_wr = in_valid && in_ready;
  wire              do_rd = out_valid && out_ready;
  assign in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_reg != rd_reg;
  assign out_data  = mem[rd_reg[AW-1:0]];
  always_ff @(posedge mclk) begin
    if (do_wr) mem[wr_reg[AW-1:0]] <= in_data;
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (do_wr) wr_reg <= wr_reg + 1'b1;
      if (do_rd) rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule // acs_fifo

//--- acs_device.sv
// What this block does
// RULE1 - Four conversion-clock periods reserved for acquisition.
// RULE2 - Late request starts on next falling edge.
// RULE3 - Early request waits for fourth falling edge.
// RULE4 - Readout during conversion or burst afterwards.
// RULE5 - Each decided bit appears immediately on output.
// RULE6 - Host grounds shift clock in simultaneous mode.
// RULE7 - Host supplies 14000 clocks for calibration.
// RULE8 - End flag falls when calibration finishes.
// RULE9 - Host may check end flag before requesting.
// RULE10 - Flag-blind host gives twenty clocks per conversion.
// RULE11 - Host recalibrates when clock shape changes.
// RULE12 - MSB first on select, fifteen shifts, then zeros.
// RULE13 - Output changes on falling shift-clock edge.
// RULE14 - End flag high during calibration or conversion.
//
// Purpose: Converter end: calibration, acquisition timing, bit decisions, serial readout.
// Assumes: Link pins are asynchronous and pass three flip-flops; analog side is a bit stream.
// Notes:   Each falling conversion clock during a conversion decides one bit from sar_bit_in.
`timescale 1ns/1ns
`include "acs_defs.svh"
module acs_device
  import acs_pkg::*;
#(
  parameter int CAL_CYCLES = `ACS_CAL_CYCLES
) (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic rst_b,
  // Link.
  acs_link_if.device link,
  // Comparator decision per bit (analog stand-in).
  input  wire logic sar_bit_in,
  // Status.
  output logic      bipolar,
  output logic      powerdown
);
  initial begin
    if (CAL_CYCLES < 1 || CAL_CYCLES > 16384) $error("CAL_CYCLES must fit the calibration counter");
  end
  localparam int SW = `ACS_SYNC_W;
  logic [SW-1:0] s_clk, s_sclk, s_cs, s_convert_request_n, s_rst, s_rng;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_clk  <= '0;
      s_sclk <= '0;
      s_cs   <= '1;
      s_convert_request_n <= '1;
      s_rst  <= '0;
      s_rng  <= '0;
    end else begin
      s_clk  <= {s_clk[SW-2:0], link.convert_request_n_clk};
      s_sclk <= {s_sclk[SW-2:0], link.shift_clk};
      s_cs   <= {s_cs[SW-2:0], link.cs_n};
      s_convert_request_n <= {s_convert_request_n[SW-2:0], link.convert_request_n};
      s_rst  <= {s_rst[SW-2:0], link.reset_n};
      s_rng  <= {s_rng[SW-2:0], link.range_or_powerdown_select};
    end
  end
  function automatic logic agreed(input logic [SW-1:0] s, input logic prev);
    return (s[1] == s[2]) ? s[1] : prev;
  endfunction
  logic clk_q, sclk_q, cs_q, convert_request_n_q, rst_q, rng_q;
  wire clk_v  = agreed(s_clk, clk_q);
  wire sclk_v = agreed(s_sclk, sclk_q);
  wire cs_v   = agreed(s_cs, cs_q);
  wire convert_request_n_v = agreed(s_convert_request_n, convert_request_n_q);
  wire rst_v  = agreed(s_rst, rst_q);
  wire rng_v  = agreed(s_rng, rng_q);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clk_q  <= 1'b0;
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
      convert_request_n_q <= 1'b1;
      rst_q  <= 1'b0;
      rng_q  <= 1'b0;
    end else begin
      clk_q  <= clk_v;
      sclk_q <= sclk_v;
      cs_q   <= cs_v;
      convert_request_n_q <= convert_request_n_v;
      rst_q  <= rst_v;
      rng_q  <= rng_v;
    end
  end
  wire clk_fall  = clk_q && !clk_v;
  wire sclk_fall = sclk_q && !sclk_v;
  wire cs_fall   = cs_q && !cs_v;
  assign bipolar   = rng_q;
  assign powerdown = 1'b0;

  acs_dev_state_t state_reg, state_next;
  logic [13:0] cal_reg;
  logic [2:0]  since_reg;
  logic [3:0]  bit_reg;
  logic [`ACS_SHIFT_BITS-1:0] res_reg;
  logic [`ACS_SHIFT_BITS-1:0] shift_reg;
  logic        sdo_reg;
  logic        eoc_reg;
  wire cal_done   = cal_reg == 14'(CAL_CYCLES - 1);
  wire acq_ok     = since_reg >= 3'(`ACS_ACQ_LATE); // [RULE1]
  wire start_now  = clk_fall && !convert_request_n_q && acq_ok;   // [RULE2] [RULE3]
  wire last_bit   = bit_reg == 4'(`ACS_SHIFT_BITS - 1);
  wire burst_mode = !sclk_q && (state_reg == ACS_IDLE); // [RULE4]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ACS_CAL:  if (clk_fall && cal_done) state_next = ACS_IDLE; // [RULE7]
      ACS_IDLE: if (start_now) state_next = ACS_CONVERT_REQUEST_N;
      ACS_CONVERT_REQUEST_N: if (clk_fall && last_bit) state_next = ACS_IDLE;
      ACS_WAIT: state_next = ACS_IDLE;
      default:  state_next = ACS_CAL;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ACS_CAL;
      cal_reg   <= '0;
      since_reg <= '0;
      bit_reg   <= '0;
      res_reg   <= '0;
      shift_reg <= '0;
      sdo_reg   <= 1'b0;
      eoc_reg   <= 1'b1;
    end else if (!rst_q) begin
      state_reg <= ACS_CAL;
      cal_reg   <= '0;
      since_reg <= '0;
      bit_reg   <= '0;
      eoc_reg   <= 1'b1;
    end else begin
      state_reg <= state_next;
      if (state_reg == ACS_CAL && clk_fall) cal_reg <= cal_reg + 1'b1;
      eoc_reg <= (state_next != ACS_IDLE); // [RULE8] [RULE14]
      if (state_reg == ACS_IDLE && clk_fall && !acq_ok) since_reg <= since_reg + 1'b1;
      if (state_reg != ACS_IDLE) since_reg <= '0;
      if (start_now) bit_reg <= '0;
      if (state_reg == ACS_CONVERT_REQUEST_N && clk_fall) begin
        bit_reg <= bit_reg + 1'b1;
        res_reg <= {res_reg[`ACS_SHIFT_BITS-2:0], sar_bit_in};
        sdo_reg <= sar_bit_in; // [RULE5]
      end
      if (cs_fall && burst_mode) begin
        shift_reg <= {res_reg[`ACS_SHIFT_BITS-2:0], 1'b0};
        sdo_reg   <= res_reg[`ACS_SHIFT_BITS-1]; // [RULE12]
      end else if (sclk_fall && state_reg == ACS_IDLE) begin
        shift_reg <= {shift_reg[`ACS_SHIFT_BITS-2:0], 1'b0};
        sdo_reg   <= shift_reg[`ACS_SHIFT_BITS-1]; // [RULE12] [RULE13]
      end
    end
  end
  assign link.sdout_o  = sdo_reg;
  assign link.sdout_oe = !cs_q;
  assign link.eoc      = eoc_reg;
endmodule // acs_device

//--- acs_host.sv
// Purpose: Host end: makes both link clocks, calibrates, converts, reads results into a FIFO.
// Assumes: Conversion clock and shift clock are divided from mclk.
// Notes:   Mode 0 reads during conversion, mode 1 reads in bursts.
`timescale 1ns/1ns
`include "acs_defs.svh"
module acs_host
  import acs_pkg::*;
#(
  parameter int CAL_CYCLES = `ACS_CAL_CYCLES
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Link.
  acs_link_if.host         link,
  // User control.
  input  wire logic        start,
  input  wire logic        burst_mode,
  input  wire logic        recal,
  input  wire logic        bipolar_sel,
  // Result stream.
  output logic             res_valid,
  input  wire logic        res_ready,
  output logic [13:0]      res_data,
  output logic             busy
);
  localparam int SW = `ACS_SYNC_W;
  logic [SW-1:0] s_eoc, s_do;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_eoc <= '1;
      s_do  <= '0;
    end else begin
      s_eoc <= {s_eoc[SW-2:0], link.eoc};
      s_do  <= {s_do[SW-2:0], link.sdout};
    end
  end
  wire eoc_v = (s_eoc[1] == s_eoc[2]) ? s_eoc[2] : 1'b1;
  wire do_v  = s_do[2];

  acs_host_state_t st_reg;
  logic [2:0]  div_reg;
  logic        clk_reg, sclk_reg;
  logic [14:0] cyc_reg;
  logic [4:0]  cnt_reg;
  logic [13:0] acc_reg;
  logic        convert_request_n_n_reg, cs_n_reg, rst_n_reg, push_reg, mode_reg;
  logic        f_ready;
  wire tick     = div_reg == 3'(`ACS_CLK_HALF_DIV - 1);
  wire clk_fall = tick && clk_reg;
  wire clk_rise = tick && !clk_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= '0;
      clk_reg <= 1'b0;
    end else begin
      div_reg <= tick ? 3'h0 : div_reg + 1'b1;
      if (tick) clk_reg <= !clk_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg     <= ACS_H_RST;
      cyc_reg    <= '0;
      cnt_reg    <= '0;
      acc_reg    <= '0;
      convert_request_n_n_reg <= 1'b1;
      cs_n_reg   <= 1'b1;
      rst_n_reg  <= 1'b0;
      sclk_reg   <= 1'b0;
      push_reg   <= 1'b0;
      mode_reg   <= 1'b0;
    end else begin
      push_reg <= 1'b0;
      case (st_reg)
        ACS_H_RST: begin
          cyc_reg <= cyc_reg + 1'b1;
          if (clk_fall && cyc_reg > 15'(`ACS_RST_HOLD)) begin
            rst_n_reg <= 1'b1;
            cyc_reg   <= '0;
            st_reg    <= ACS_H_CAL;
          end
        end
        ACS_H_CAL: begin
          if (clk_fall) cyc_reg <= cyc_reg + 1'b1;
          if (cyc_reg > 15'(CAL_CYCLES + 8) && !eoc_v) st_reg <= ACS_H_IDLE; // [RULE7] [RULE8]
        end
        ACS_H_IDLE: if (recal) begin
          rst_n_reg <= 1'b0; // [RULE11]
          cyc_reg   <= '0;
          st_reg    <= ACS_H_RST;
        end else if (start && !eoc_v && f_ready && clk_rise) begin // [RULE9]
          mode_reg   <= burst_mode;
          convert_request_n_n_reg <= 1'b0;
          cs_n_reg   <= burst_mode;
          cnt_reg    <= '0;
          st_reg     <= ACS_H_CONVERT_REQUEST_N;
        end
        ACS_H_CONVERT_REQUEST_N: if (clk_rise) begin
          convert_request_n_n_reg <= 1'b1;
          cnt_reg    <= cnt_reg + 1'b1;
          if (!mode_reg && eoc_v && cnt_reg != 5'h0) acc_reg <= {acc_reg[12:0], do_v}; // [RULE6]
          if (cnt_reg == 5'(`ACS_CONVERT_REQUEST_N_CYCLES - 1)) begin // [RULE10]
            cs_n_reg <= 1'b0;
            cnt_reg  <= '0;
            push_reg <= !mode_reg;
            st_reg   <= mode_reg ? ACS_H_READ : ACS_H_IDLE;
            if (!mode_reg) cs_n_reg <= 1'b1;
          end
        end
        ACS_H_READ: if (tick) begin
          sclk_reg <= !sclk_reg; // [RULE4]
          if (sclk_reg) begin
            acc_reg <= {acc_reg[12:0], do_v};
            cnt_reg <= cnt_reg + 1'b1;
            if (cnt_reg == 5'(`ACS_RES_BITS - 1)) begin
              cs_n_reg <= 1'b1;
              push_reg <= 1'b1;
              st_reg   <= ACS_H_IDLE;
            end
          end
        end
        default: st_reg <= ACS_H_RST;
      endcase
    end
  end

  acs_fifo #(.WIDTH(`ACS_RES_BITS), .DEPTH(`ACS_FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_valid  (push_reg),
    .in_ready  (f_ready),
    .in_data   (acc_reg),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );
  assign busy                           = st_reg != ACS_H_IDLE;
  assign link.convert_request_n_clk                  = clk_reg;
  assign link.shift_clk                 = sclk_reg;
  assign link.cs_n                      = cs_n_reg;
  assign link.convert_request_n         = convert_request_n_n_reg;
  assign link.reset_n                   = rst_n_reg;
  assign link.range_or_powerdown_select = bipolar_sel;
endmodule // acs_host

//--- acs_link_chk.sv
// Purpose: Assertions on the link between the two ends.
// Assumes: Link pins reach the converter through three flops.
// Notes:   Windows allow for that sync delay.
`timescale 1ns/1ns
module acs_link_chk #(
  parameter int CAL_CYCLES = 40
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_b,
  // Link pins.
  input wire logic convert_request_n,
  input wire logic convert_request_n_clk,
  input wire logic shift_clk,
  input wire logic cs_n,
  input wire logic reset_n,
  input wire logic sdout_o,
  input wire logic sdout_oe,
  input wire logic eoc
);
  logic [19:0] hi_reg;
  logic [19:0] lo_reg;
  logic [3:0]  age_reg;
  logic [3:0]  rhi_reg;
  logic        cal_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hi_reg <= 20'h0;
      lo_reg <= 20'h0;
      age_reg <= 4'h0;
      rhi_reg <= 4'h0;
      cal_reg <= 1'b0;
    end else begin
      hi_reg <= eoc ? hi_reg + 20'h1 : 20'h0;
      lo_reg <= eoc ? 20'h0 : lo_reg + 20'h1;
      age_reg <= ($fell(convert_request_n_clk) || $fell(shift_clk)) ? 4'h0
                 : age_reg + {3'h0, age_reg != 4'hf};
      rhi_reg <= !reset_n ? 4'h0 : rhi_reg + {3'h0, rhi_reg != 4'hf};
      cal_reg <= !reset_n ? 1'b0 : (cal_reg || $fell(eoc));
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  AST_OE_ON: assert property ((!cs_n) [*6] |-> sdout_oe)
    else $error("serial output not driven while selected");
  AST_OE_OFF: assert property ($rose(cs_n) |-> ##[1:5] !sdout_oe)
    else $error("serial output still driven after deselect");
  AST_OUT_ON_FALL: assert property (sdout_oe && $past(sdout_oe) && $past(sdout_oe, 2)
    && $changed(sdout_o) |-> age_reg inside {[4'h1:4'h5]})
    else $error("serial output changed away from a clock fall");
  AST_START_LATE: assert property (!convert_request_n && !eoc && cal_reg
    && lo_reg >= 20'd40 |-> ##[1:16] eoc)
    else $error("late request did not start on next fall");
  AST_ACQ_GAP: assert property ($rose(eoc) && cal_reg && rhi_reg == 4'hf
    |-> lo_reg >= 20'd28)
    else $error("acquisition window too short");
  AST_CONVERT_REQUEST_N_LEN: assert property ($fell(eoc) && cal_reg
    |-> hi_reg inside {[20'd116:20'd124]})
    else $error("conversion not fifteen decisions long");
  AST_CAL_LEN: assert property ($fell(eoc) && !cal_reg
    |-> hi_reg >= 20'(CAL_CYCLES * 8 - 16))
    else $error("calibration ended early");
  AST_CAL_ON_RESET: assert property ($fell(reset_n) |-> ##[1:6] eoc)
    else $error("end flag not raised by link reset");
  AST_EOC_IN_RESET: assert property ((!reset_n) [*6] |-> eoc)
    else $error("end flag low during link reset");
endmodule // acs_link_chk

//--- tb_adc_conversion_sequencer.sv
// Purpose: Bench for both link ends of the conversion sequencer.
// Assumes: Calibration shortened to 40 conversion clocks.
// Notes:   Outputs are sampled on the falling mclk edge.
`timescale 1ns/1ns
module tb_adc_conversion_sequencer;
  localparam int CAL = 40;
  localparam int CAL_MIN = CAL * 8 - 16;
  logic        mclk;
  logic        rst_b;
  logic        sar_bit_in;
  logic        start;
  logic        burst_mode;
  logic        recal;
  logic        bipolar_sel;
  logic        res_ready;
  logic        res_valid;
  logic [13:0] res_data;
  logic        busy;
  int          num_errors;
  int          total_checks;
  acs_link_if link_if ();
  acs_device #(.CAL_CYCLES(CAL)) i_acs_device (
    .mclk(mclk), .rst_b(rst_b), .link(link_if.device),
    .sar_bit_in(sar_bit_in), .bipolar(), .powerdown()
  );
  acs_host #(.CAL_CYCLES(CAL)) i_acs_host (
    .mclk(mclk), .rst_b(rst_b), .link(link_if.host), .start(start),
    .burst_mode(burst_mode), .recal(recal), .bipolar_sel(bipolar_sel),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data), .busy(busy)
  );
  acs_link_chk #(.CAL_CYCLES(CAL)) i_acs_link_chk (
    .mclk(mclk), .rst_b(rst_b), .convert_request_n(link_if.convert_request_n),
    .convert_request_n_clk(link_if.convert_request_n_clk), .shift_clk(link_if.shift_clk), .cs_n(link_if.cs_n),
    .reset_n(link_if.reset_n), .sdout_o(link_if.sdout_o),
    .sdout_oe(link_if.sdout_oe), .eoc(link_if.eoc)
  );
  always #2 mclk = ~mclk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic calib();
    int n;
    check(16'(link_if.eoc), 16'h1);
    for (n = 0; n < 4 * CAL_MIN && link_if.eoc !== 1'b0; n++) @(negedge mclk);
    check(16'(n >= CAL_MIN), 16'h1);
    check(16'(link_if.eoc), 16'h0);
    for (n = 0; n < 400 && busy !== 1'b0; n++) @(negedge mclk);
    check(16'(busy), 16'h0);
  endtask
  task automatic run_one(input logic sar, input logic [13:0] exp);
    int n;
    @(posedge mclk);
    sar_bit_in <= sar;
    start <= 1'b1;
    for (n = 0; n < 40 && busy !== 1'b1; n++) @(negedge mclk);
    @(posedge mclk);
    start <= 1'b0;
    for (n = 0; n < 4000 && res_valid !== 1'b1; n++) @(negedge mclk);
    check({1'b0, res_valid, res_data}, {2'b01, exp});
    @(posedge mclk);
    res_ready <= 1'b1;
    @(posedge mclk);
    res_ready <= 1'b0;
    for (n = 0; n < 4000 && busy !== 1'b0; n++) @(negedge mclk);
  endtask
  task automatic back_to_back();
    int n;
    int k;
    @(posedge mclk);
    sar_bit_in <= 1'b1;
    start <= 1'b1;
    for (k = 0; k < 2; k++) begin
      for (n = 0; n < 4000 && res_valid !== 1'b1; n++) @(negedge mclk);
      check({1'b0, res_valid, res_data}, 16'h7fff);
      @(posedge mclk);
      res_ready <= 1'b1;
      @(posedge mclk);
      res_ready <= 1'b0;
    end
    start <= 1'b0;
    @(posedge mclk);
    res_ready <= 1'b1;
    for (n = 0; n < 4000 && (busy | res_valid) !== 1'b0; n++) @(negedge mclk);
    @(posedge mclk);
    res_ready <= 1'b0;
  endtask
  task automatic fill_fifo();
    int n;
    int k;
    for (k = 0; k < 8; k++) begin
      @(posedge mclk);
      sar_bit_in <= k[0];
      start <= 1'b1;
      for (n = 0; n < 40 && busy !== 1'b1; n++) @(negedge mclk);
      @(posedge mclk);
      start <= 1'b0;
      for (n = 0; n < 4000 && busy !== 1'b0; n++) @(negedge mclk);
    end
    @(posedge mclk);
    res_ready <= 1'b1;
    for (k = 0; k < 8; k++) begin
      @(negedge mclk);
      check({1'b0, res_valid, res_data}, {2'b01, {14{k[0]}}});
    end
    @(posedge mclk);
    res_ready <= 1'b0;
    @(negedge mclk);
    check(16'(res_valid), 16'h0);
  endtask
  task automatic recal_run();
    int n;
    @(posedge mclk);
    recal <= 1'b1;
    @(posedge mclk);
    recal <= 1'b0;
    for (n = 0; n < 40 && link_if.eoc !== 1'b1; n++) @(negedge mclk);
    calib();
    run_one(1'b1, 14'h3fff);
  endtask
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    sar_bit_in = 1'b0;
    start = 1'b0;
    burst_mode = 1'b0;
    recal = 1'b0;
    bipolar_sel = 1'b0;
    res_ready = 1'b0;
    num_errors = 0;
    total_checks = 0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    calib();
    run_one(1'b1, 14'h3fff);
    run_one(1'b0, 14'h0000);
    back_to_back();
    @(posedge mclk);
    burst_mode <= 1'b1;
    repeat (16) @(posedge mclk);
    run_one(1'b1, 14'h3fff);
    run_one(1'b0, 14'h0000);
    fill_fifo();
    recal_run();
    finish_test();
  end
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
endmodule // tb_adc_conversion_sequencer
